// ==== src/usdp_pkg.sv ====
package usdp_pkg;

   // register byte addresses
   localparam logic [31:0] DATA_ADDR     = 32'h5000_1164;
   localparam logic [31:0] CTRL_ADDR     = 32'h5000_1180;
   localparam logic [31:0] STAT_ADDR     = 32'h5000_1184;
   localparam logic [31:0] IRQ_STAT_ADDR = 32'h5000_1188;
   localparam logic [31:0] IRQ_MASK_ADDR = 32'h5000_118C;

   // control field positions and reset value
   localparam int          CTRL_FIFO_EN_BIT = 0;
   localparam int          CTRL_IR_BIT      = 1;
   localparam logic [1:0]  CTRL_RESET       = 2'h0;

   // line status field positions
   localparam int STAT_READY_BIT      = 0;
   localparam int STAT_OE_BIT         = 1;
   localparam int STAT_TX_FULL_BIT    = 2;
   localparam int STAT_RX_FULL_BIT    = 3;
   localparam int STAT_HOLD_EMPTY_BIT = 5;

   // interrupt event positions, shared by status and mask
   localparam int         IRQ_W             = 4;
   localparam int         EV_RX_BIT         = 0;
   localparam int         EV_OE_BIT         = 1;
   localparam int         EV_HOLD_EMPTY_BIT = 2;
   localparam int         EV_TX_LOST_BIT    = 3;
   localparam logic [3:0] IRQ_RESET         = 4'h0;

   // data defaults
   localparam int          FIFO_DEPTH = 16;
   localparam logic [7:0]  BYTE_RESET = 8'h00;
   localparam logic [31:0] WORD_RESET = 32'h0000_0000;

   // one character on the serial side
   typedef struct packed {
      logic       valid;
      logic [7:0] data;
   } usdp_char_t;

   // one register bus request
   typedef struct packed {
      logic [31:0] addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } usdp_bus_req_t;

endpackage

// ==== src/usdp_fifo.sv ====
`timescale 1ns/1ps
`default_nettype none

// small character fifo; depth must be a power of two
module usdp_fifo #(
   parameter int W     = 8,
   parameter int DEPTH = 16
) (
   // clock and reset
   input  wire logic                       ref_clk,
   input  wire logic                       rstn,
   // control
   input  wire logic                       flush,
   // write side
   input  wire logic                       push,
   input  wire logic [W-1:0]               wdata,
   // read side
   input  wire logic                       pop,
   output logic      [W-1:0]               head_q,
   // state
   output logic                            full,
   output logic                            empty,
   output logic      [$clog2(DEPTH+1)-1:0] count_q
);

   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH+1);

   logic [W-1:0]  mem [DEPTH];
   logic [AW-1:0] wr_ptr_q;
   logic [AW-1:0] rd_ptr_q;
   logic [AW-1:0] rd_next;
   logic          do_push;
   logic          do_pop;
   logic [W-1:0]  head_d;

   // pushes into a full fifo and pops from an empty one are ignored
   assign full    = count_q == CW'(DEPTH);
   assign empty   = count_q == '0;
   assign do_push = push & ~full;
   assign do_pop  = pop & ~empty;
   assign rd_next = do_pop ? rd_ptr_q + AW'(1) : rd_ptr_q;
   // prefetch so the head register is current the cycle after a push
   assign head_d  = (do_push && wr_ptr_q == rd_next) ? wdata : mem[rd_next];

   // storage has no reset, only the pointers, level and head do
   always_ff @(posedge ref_clk) begin
      if (do_push) begin
         mem[wr_ptr_q] <= wdata;
      end
   end

   // pointers, level and registered head
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         count_q  <= '0;
         head_q   <= '0;
      end else if (flush) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         count_q  <= '0;
      end else begin
         wr_ptr_q <= do_push ? wr_ptr_q + AW'(1) : wr_ptr_q;
         rd_ptr_q <= rd_next;
         count_q  <= count_q + CW'(do_push) - CW'(do_pop);
         head_q   <= head_d;
      end
   end

endmodule

`default_nettype wire

// ==== src/usdp_irq.sv ====
`timescale 1ns/1ps
`default_nettype none

// sticky event status, mask and one level interrupt
module usdp_irq #(
   parameter int N = 4
) (
   // clock and reset
   input  wire logic         ref_clk,
   input  wire logic         rstn,
   // events, one cycle pulses
   input  wire logic [N-1:0] event_i,
   // software access
   input  wire logic         clr_wr,
   input  wire logic         mask_wr,
   input  wire logic [N-1:0] wdata,
   // state
   output logic      [N-1:0] status_q,
   output logic      [N-1:0] mask_q,
   output logic              irq_q
);

   logic [N-1:0] status_d;

   // write one to clear; a new event in the same cycle wins
   assign status_d = (status_q & ~(clr_wr ? wdata : '0)) | event_i;

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         status_q <= '0;
         mask_q   <= '0;
         irq_q    <= 1'b0;
      end else begin
         status_q <= status_d;
         mask_q   <= mask_wr ? wdata : mask_q;
         irq_q    <= |(status_d & (mask_wr ? wdata : mask_q));
      end
   end

endmodule

`default_nettype wire

// ==== src/uart_shadow_data_port.sv ====
// Summary of operation
// - data location is one word alias of the receive and transmit data port
// - reads return received byte from serial or infrared input by mode
// - receive data counts as valid only while data ready is set
// - no fifo: unread byte is overwritten by the next, overrun flagged
// - fifo on: a read returns and removes the receive fifo head
// - receive fifo full: new character dropped, contents kept, overrun
// - written low byte is sent unchanged, routed to serial or infrared output by mode
// - no fifo: a write clears holding empty, later writes overwrite
// - fifo on: writes accepted up to the transmit fifo depth
// - a write to a full transmit fifo is discarded
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module uart_shadow_data_port #(
   parameter int DEPTH = usdp_pkg::FIFO_DEPTH
) (
   // clock and reset
   input  wire logic                   ref_clk,
   input  wire logic                   rstn,
   // register bus
   input  wire usdp_pkg::usdp_bus_req_t bus_req,
   output logic [31:0]                 rd_data_q,
   // receive characters from the deserialisers
   input  wire usdp_pkg::usdp_char_t   sin_rx,
   input  wire usdp_pkg::usdp_char_t   sir_rx,
   // transmit character to the serialiser
   output var usdp_pkg::usdp_char_t    tx_char_q,
   output logic                        tx_ir_q,
   input  wire logic                   tx_take,
   // interrupt
   output logic                        irq_q
);

   // fifo levels stay open; the full and empty flags are enough here

   // control and flags
   logic [1:0]              ctrl_q;
   logic                    fifo_en;
   logic                    ir_mode;
   logic [7:0]              receive_buffer_q;
   logic                    data_ready_q;
   logic                    oe_q;
   logic [7:0]              transmit_holding_q;
   logic                    holding_full_q;
   logic                    hold_empty_prev_q;

   // bus decode
   logic                    sel_data;
   logic                    sel_ctrl;
   logic                    sel_stat;
   logic                    sel_istat;
   logic                    sel_imask;
   logic                    wr_data;
   logic                    rd_data_hit;
   logic                    wr_ctrl;
   logic                    rd_stat;
   logic                    flush;

   // receive path
   usdp_pkg::usdp_char_t    rx_in;
   logic                    rx_push;
   logic                    rx_full;
   logic                    rx_empty;
   logic [7:0]              rx_head;
   logic                    rx_overrun;
   logic                    rx_stored;
   logic                    rx_data_ready_flag;

   // transmit path
   logic                    tx_push;
   logic                    tx_lost;
   logic                    tx_full;
   logic                    tx_empty;
   logic [7:0]              tx_head;
   logic                    stage_free;
   logic                    tx_avail;
   logic                    tx_move;
   logic [7:0]              tx_src;
   logic                    tx_holding_empty_flag;

   // registers seen by software
   logic [31:0]             stat_word;
   logic [31:0]             rd_mux;
   logic [usdp_pkg::IRQ_W-1:0] events;
   logic [usdp_pkg::IRQ_W-1:0] irq_status;
   logic [usdp_pkg::IRQ_W-1:0] irq_mask;

   // full-address compare; unmapped reads return zero
   function automatic logic hit(input logic [31:0] a, input logic [31:0] r);
      hit = a == r;
   endfunction

   assign sel_data  = hit(bus_req.addr, usdp_pkg::DATA_ADDR);
   assign sel_ctrl  = hit(bus_req.addr, usdp_pkg::CTRL_ADDR);
   assign sel_stat  = hit(bus_req.addr, usdp_pkg::STAT_ADDR);
   assign sel_istat = hit(bus_req.addr, usdp_pkg::IRQ_STAT_ADDR);
   assign sel_imask = hit(bus_req.addr, usdp_pkg::IRQ_MASK_ADDR);

   // strobes qualified by decode
   assign wr_data     = bus_req.wr & sel_data;
   assign rd_data_hit = bus_req.rd & sel_data;
   assign wr_ctrl     = bus_req.wr & sel_ctrl;
   assign rd_stat     = bus_req.rd & sel_stat;

   assign fifo_en = ctrl_q[usdp_pkg::CTRL_FIFO_EN_BIT];
   assign ir_mode = ctrl_q[usdp_pkg::CTRL_IR_BIT];

   // toggling fifo enable empties both fifos, stale data would mislead
   assign flush = wr_ctrl &
                  (bus_req.wdata[usdp_pkg::CTRL_FIFO_EN_BIT] != fifo_en);

   // receive side
   // one character per cycle at most, no back pressure to the line

   // input chosen by mode
   assign rx_in = ir_mode ? sir_rx : sin_rx;

   // fifo mode pushes; a full fifo keeps its contents
   assign rx_push = rx_in.valid & fifo_en;

   // overrun in either mode; without fifo a read in the same cycle frees the buffer
   assign rx_overrun = rx_in.valid &
                       (fifo_en ? rx_full
                                : (data_ready_q & ~rd_data_hit));
   assign rx_stored  = rx_in.valid & ~(fifo_en & rx_full);

   // data ready: buffer held, or fifo not empty
   assign rx_data_ready_flag = fifo_en ? ~rx_empty : data_ready_q;

   usdp_fifo #(
      .W     (8),
      .DEPTH (DEPTH)
   ) u_rx_fifo (
      .ref_clk (ref_clk),
      .rstn    (rstn),
      .flush   (flush),
      .push    (rx_push),
      .wdata   (rx_in.data),
      .pop     (rd_data_hit & fifo_en),
      .head_q  (rx_head),
      .full    (rx_full),
      .empty   (rx_empty),
      .count_q ()
   );

   // single receive buffer, the newest byte always lands
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         receive_buffer_q <= usdp_pkg::BYTE_RESET;
         data_ready_q     <= 1'b0;
      end else begin
         if (rx_in.valid && !fifo_en) begin
            receive_buffer_q <= rx_in.data;
         end
         // arrival wins over the clearing read
         data_ready_q <= ~fifo_en &
                         (rx_in.valid | (data_ready_q & ~rd_data_hit));
      end
   end

   // overrun sticks until line status is read; new overrun wins
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         oe_q <= 1'b0;
      end else begin
         oe_q <= rx_overrun | (oe_q & ~rd_stat);
      end
   end

   // transmit side
   // the output stage holds one more character beyond the fifo depth

   // fifo push, dropped when full
   assign tx_push = wr_data & fifo_en;
   assign tx_lost = wr_data & fifo_en & tx_full;

   usdp_fifo #(
      .W     (8),
      .DEPTH (DEPTH)
   ) u_tx_fifo (
      .ref_clk (ref_clk),
      .rstn    (rstn),
      .flush   (flush),
      .push    (tx_push),
      .wdata   (bus_req.wdata[7:0]),
      .pop     (tx_move & fifo_en),
      .head_q  (tx_head),
      .full    (tx_full),
      .empty   (tx_empty),
      .count_q ()
   );

   // output stage refills when empty or being taken
   assign stage_free = ~tx_char_q.valid | tx_take;
   assign tx_avail   = fifo_en ? ~tx_empty : holding_full_q;
   assign tx_move    = stage_free & tx_avail;
   assign tx_src     = fifo_en ? tx_head : transmit_holding_q;

   // holding empty: fifo empty, or single holding register free
   assign tx_holding_empty_flag = fifo_en ? tx_empty
                                          : ~holding_full_q;

   // single holding register; a second write overwrites
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         transmit_holding_q <= usdp_pkg::BYTE_RESET;
         holding_full_q     <= 1'b0;
      end else begin
         if (wr_data && !fifo_en) begin
            transmit_holding_q <= bus_req.wdata[7:0];
         end
         // a write in the move cycle keeps the register full
         holding_full_q <= ~fifo_en &
                           (wr_data | (holding_full_q & ~tx_move));
      end
   end

   // character handed to the serialiser with its route
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         tx_char_q <= '0;
         tx_ir_q   <= 1'b0;
      end else begin
         if (tx_move) begin
            tx_char_q <= '{valid: 1'b1, data: tx_src};
            tx_ir_q   <= ir_mode;
         end else if (tx_take) begin
            tx_char_q.valid <= 1'b0;
         end
      end
   end

   // edge of holding empty; resets high like the idle flag, no false edge
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         hold_empty_prev_q <= 1'b1;
      end else begin
         hold_empty_prev_q <= tx_holding_empty_flag;
      end
   end

   // control, status and interrupts
   // line status is built at read time, only overrun is stored

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         ctrl_q <= usdp_pkg::CTRL_RESET;
      end else if (wr_ctrl) begin
         ctrl_q <= bus_req.wdata[1:0];
      end
   end

   // event pulses feeding the sticky status
   assign events[usdp_pkg::EV_RX_BIT]         = rx_stored;
   assign events[usdp_pkg::EV_OE_BIT]         = rx_overrun;
   assign events[usdp_pkg::EV_HOLD_EMPTY_BIT] = tx_holding_empty_flag &
                                                ~hold_empty_prev_q;
   assign events[usdp_pkg::EV_TX_LOST_BIT]    = tx_lost;

   usdp_irq #(
      .N (usdp_pkg::IRQ_W)
   ) u_irq (
      .ref_clk  (ref_clk),
      .rstn     (rstn),
      .event_i  (events),
      .clr_wr   (bus_req.wr & sel_istat),
      .mask_wr  (bus_req.wr & sel_imask),
      .wdata    (bus_req.wdata[usdp_pkg::IRQ_W-1:0]),
      .status_q (irq_status),
      .mask_q   (irq_mask),
      .irq_q    (irq_q)
   );

   // line status word
   always_comb begin
      stat_word = usdp_pkg::WORD_RESET;
      stat_word[usdp_pkg::STAT_READY_BIT]      = rx_data_ready_flag;
      stat_word[usdp_pkg::STAT_OE_BIT]         = oe_q;
      stat_word[usdp_pkg::STAT_TX_FULL_BIT]    = fifo_en & tx_full;
      stat_word[usdp_pkg::STAT_RX_FULL_BIT]    = fifo_en & rx_full;
      stat_word[usdp_pkg::STAT_HOLD_EMPTY_BIT] = tx_holding_empty_flag;
   end

   // read selection; upper data bits are reserved and read zero
   assign rd_mux =
      sel_data  ? {24'h00_0000,
                   fifo_en ? rx_head : receive_buffer_q} :
      sel_ctrl  ? {30'h0000_0000, ctrl_q} :
      sel_stat  ? stat_word :
      sel_istat ? {28'h000_0000, irq_status} :
      sel_imask ? {28'h000_0000, irq_mask} :
      usdp_pkg::WORD_RESET;

   // read data stand only in the cycle after the strobe
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         rd_data_q <= usdp_pkg::WORD_RESET;
      end else begin
         rd_data_q <= bus_req.rd ? rd_mux : usdp_pkg::WORD_RESET;
      end
   end

endmodule

`default_nettype wire

// ==== tb/usdp_properties.sv ====
`timescale 1ns/1ps
`default_nettype none

module usdp_properties (
   // clock and reset
   input wire logic                    ref_clk,
   input wire logic                    rstn,
   // register bus
   input wire usdp_pkg::usdp_bus_req_t bus_req,
   input wire logic [31:0]             rd_data_q,
   // characters
   input wire usdp_pkg::usdp_char_t    sin_rx,
   input wire usdp_pkg::usdp_char_t    sir_rx,
   input wire usdp_pkg::usdp_char_t    tx_char_q,
   input wire logic                    tx_ir_q,
   input wire logic                    tx_take,
   // interrupt
   input wire logic                    irq_q
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);

   logic       ctrl_wr;
   logic       mask_wr;
   logic       data_wr;
   logic [1:0] ctrl_q;
   logic [3:0] msk_q;

   // shadow of mode and mask, since the checker only sees the bus
   assign ctrl_wr = bus_req.wr && bus_req.addr == usdp_pkg::CTRL_ADDR;
   assign mask_wr = bus_req.wr && bus_req.addr == usdp_pkg::IRQ_MASK_ADDR;
   assign data_wr = bus_req.wr && bus_req.addr == usdp_pkg::DATA_ADDR;
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         ctrl_q <= usdp_pkg::CTRL_RESET;
         msk_q  <= usdp_pkg::IRQ_RESET;
      end else begin
         if (ctrl_wr) ctrl_q <= bus_req.wdata[1:0];
         if (mask_wr) msk_q <= bus_req.wdata[3:0];
      end
   end

   property p_rd_idle;
      !$past(bus_req.rd) |-> rd_data_q == 32'h0000_0000;
   endproperty
   a_rd_idle: assert property (p_rd_idle)
      else $error("read data outside its slot");
   property p_rd_byte;
      $past(bus_req.rd) && $past(bus_req.addr) == usdp_pkg::DATA_ADDR
         |-> rd_data_q[31:8] == 24'h00_0000;
   endproperty
   a_rd_byte: assert property (p_rd_byte)
      else $error("data read with upper bits set");
   property p_tx_hold;
      tx_char_q.valid && !tx_take
         |=> tx_char_q.valid && $stable(tx_char_q.data) && $stable(tx_ir_q);
   endproperty
   a_tx_hold: assert property (p_tx_hold)
      else $error("transmit character changed before taken");
   property p_tx_plain;
      data_wr && !ctrl_q[0] && !tx_char_q.valid |-> ##[1:2] tx_char_q.valid;
   endproperty
   a_tx_plain: assert property (p_tx_plain)
      else $error("written character not offered");
   property p_tx_fifo;
      data_wr && ctrl_q[0] && !tx_char_q.valid |-> ##[1:3] tx_char_q.valid;
   endproperty
   a_tx_fifo: assert property (p_tx_fifo)
      else $error("queued character not offered");
   property p_ir_load;
      $rose(tx_char_q.valid) |-> tx_ir_q == ctrl_q[1];
   endproperty
   a_ir_load: assert property (p_ir_load)
      else $error("transmit output select wrong");
   property p_irq_mask;
      $past(msk_q) == 4'h0 && msk_q == 4'h0 |-> !irq_q;
   endproperty
   a_irq_mask: assert property (p_irq_mask)
      else $error("interrupt with all events masked");
   sequence s_rx_stat;
      sin_rx.valid && !ctrl_q[1] && !bus_req.rd
      ##1 bus_req.rd && bus_req.addr == usdp_pkg::STAT_ADDR;
   endsequence
   property p_rx_ready;
      s_rx_stat |=> rd_data_q[usdp_pkg::STAT_READY_BIT];
   endproperty
   a_rx_ready: assert property (p_rx_ready)
      else $error("data ready missing after a character");

   // main scenarios reached
   c_take: cover property (tx_char_q.valid && tx_take);
   c_irq: cover property ($rose(irq_q));
   c_rx: cover property (s_rx_stat);
endmodule

`default_nettype wire

// ==== tb/usdp_link_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// far side: deserialisers feeding the port, serialiser taking from it
module usdp_link_model (
   // clock and reset
   input  wire logic                 ref_clk,
   input  wire logic                 rstn,
   // received characters towards the port
   output var usdp_pkg::usdp_char_t  sin_rx,
   output var usdp_pkg::usdp_char_t  sir_rx,
   // characters from the port
   input  wire usdp_pkg::usdp_char_t tx_char_q,
   input  wire logic                 tx_ir_q,
   output logic                      tx_take
);
   int         take_delay = 0;
   int         wait_n;
   logic [8:0] got[$];

   initial begin
      sin_rx = '0;
      sir_rx = '0;
   end

   // the unselected input carries a decoy; idle lines show inverted data
   task automatic send(input logic ir, input logic [7:0] d);
      sin_rx <= '{1'b1, ir ? ~d : d};
      sir_rx <= '{1'b1, ir ? d : ~d};
      @(posedge ref_clk);
      sin_rx <= '{1'b0, ~d};
      sir_rx <= '{1'b0, ~d};
   endtask

   // a slow serialiser: stall take_delay cycles before each take
   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         tx_take <= 1'b0;
         wait_n  <= 0;
      end else begin
         tx_take <= 1'b0;
         if (tx_char_q.valid && !tx_take) begin
            if (wait_n >= take_delay) begin
               tx_take <= 1'b1;
               got.push_back({tx_ir_q, tx_char_q.data});
               wait_n  <= 0;
            end else begin
               wait_n <= wait_n + 1;
            end
         end
      end
   end
endmodule

`default_nettype wire

// ==== tb/uart_shadow_data_port_bench.sv ====
`timescale 1ns/1ps
`default_nettype none

module uart_shadow_data_port_bench;
   localparam int          D     = 4;
   localparam logic [31:0] dat_a = usdp_pkg::DATA_ADDR;
   localparam logic [31:0] ctl_a = usdp_pkg::CTRL_ADDR;
   localparam logic [31:0] sta_a = usdp_pkg::STAT_ADDR;
   localparam logic [31:0] ist_a = usdp_pkg::IRQ_STAT_ADDR;
   localparam logic [31:0] msk_a = usdp_pkg::IRQ_MASK_ADDR;
   logic                    ref_clk = 1'b0;
   logic                    rstn = 1'b0;
   usdp_pkg::usdp_bus_req_t bus_req = '0;
   logic [31:0]             rd_data_q;
   usdp_pkg::usdp_char_t    sin_rx;
   usdp_pkg::usdp_char_t    sir_rx;
   usdp_pkg::usdp_char_t    tx_char_q;
   logic                    tx_ir_q;
   logic                    tx_take;
   logic                    irq_q;
   int                      n_errors = 0;
   int                      checks_done = 0;

   always #25 ref_clk = ~ref_clk;

   uart_shadow_data_port #(.DEPTH(D)) uart_shadow_data_port_i (
      .ref_clk(ref_clk), .rstn(rstn), .bus_req(bus_req),
      .rd_data_q(rd_data_q), .sin_rx(sin_rx), .sir_rx(sir_rx),
      .tx_char_q(tx_char_q), .tx_ir_q(tx_ir_q), .tx_take(tx_take),
      .irq_q(irq_q));
   usdp_link_model usdp_link_model_i (
      .ref_clk(ref_clk), .rstn(rstn), .sin_rx(sin_rx), .sir_rx(sir_rx),
      .tx_char_q(tx_char_q), .tx_ir_q(tx_ir_q), .tx_take(tx_take));

   task automatic conclude();
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // one bus cycle; strobes stay until the next call changes them
   task automatic step(input usdp_pkg::usdp_bus_req_t r);
      bus_req <= r;
      @(posedge ref_clk);
   endtask
   task automatic idle(input int n);
      repeat (n) step('0);
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      step('{a, d, 1'b1, 1'b0});
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [31:0] a, input logic [31:0] e,
                     input logic [31:0] m = 32'hFFFF_FFFF);
      step('{a, 32'h0000_0000, 1'b0, 1'b1});
      step('0);
      chk(rd_data_q & m, e);
   endtask
   task automatic wait_got(input int n);
      int k = 0;
      while (usdp_link_model_i.got.size() < n && k < 2000) begin
         @(posedge ref_clk);
         k++;
      end
      if (usdp_link_model_i.got.size() < n) begin
         n_errors++;
         conclude();
      end
   endtask

   initial begin
      repeat (12) @(posedge ref_clk);
      rstn <= 1'b1;
      @(posedge ref_clk);
      // reset values and an unmapped hole
      wr(32'h5000_1190, 32'hFFFF_FFFF);
      rd(32'h5000_1190, 32'h0000_0000);
      rd(ctl_a, 32'h0000_0000);
      rd(sta_a, 32'h0000_0020);
      rd(dat_a, 32'h0000_0000);
      rd(ist_a, 32'h0000_0000);
      rd(msk_a, 32'h0000_0000);
      // serial receive, interrupt masked then unmasked
      usdp_link_model_i.send(1'b0, 8'hA5);
      rd(sta_a, 32'h0000_0021);
      chk(32'(irq_q), 32'h0000_0000);
      wr(msk_a, 32'h0000_000F);
      idle(2);
      chk(32'(irq_q), 32'h0000_0001);
      rd(dat_a, 32'h0000_00A5);
      rd(sta_a, 32'h0000_0020);
      rd(ist_a, 32'h0000_0001);
      wr(ist_a, 32'h0000_0001);
      idle(2);
      chk(32'(irq_q), 32'h0000_0000);
      // unread byte overwritten by the next
      usdp_link_model_i.send(1'b0, 8'h11);
      idle(1);
      usdp_link_model_i.send(1'b0, 8'h22);
      rd(sta_a, 32'h0000_0023);
      rd(dat_a, 32'h0000_0022);
      rd(sta_a, 32'h0000_0020);
      rd(ist_a, 32'h0000_0003);
      wr(ist_a, 32'h0000_000F);
      // infrared receive and transmit
      wr(ctl_a, 32'h0000_0002);
      idle(1);
      usdp_link_model_i.send(1'b1, 8'h5A);
      rd(dat_a, 32'h0000_005A);
      wr(dat_a, 32'h0000_0144);
      idle(1);
      wait_got(1);
      chk(32'(usdp_link_model_i.got[0]), 32'h0000_0144);
      usdp_link_model_i.got.delete();
      // no fifo: second write before empty overwrites the held byte
      usdp_link_model_i.take_delay = 8;
      wr(ctl_a, 32'h0000_0000);
      wr(dat_a, 32'h0000_0031);
      idle(3);
      wr(dat_a, 32'h0000_0032);
      wr(dat_a, 32'h0000_0033);
      rd(sta_a, 32'h0000_0000, 32'h0000_0020);
      wait_got(2);
      idle(20);
      chk(32'(usdp_link_model_i.got.size()), 32'h0000_0002);
      chk(32'(usdp_link_model_i.got[0]), 32'h0000_0031);
      chk(32'(usdp_link_model_i.got[1]), 32'h0000_0033);
      // fifo receive: fill past depth, then drain in order
      wr(ctl_a, 32'h0000_0001);
      idle(1);
      for (int i = 0; i <= D; i++) begin
         usdp_link_model_i.send(1'b0, 8'(i + 1));
         idle(1);
      end
      rd(sta_a, 32'h0000_002B);
      for (int i = 0; i < D; i++) rd(dat_a, 32'(i + 1));
      rd(sta_a, 32'h0000_0020);
      // fifo transmit with a stalled far side: one write too many
      usdp_link_model_i.got.delete();
      usdp_link_model_i.take_delay = 30;
      wr(dat_a, 32'h0000_0060);
      idle(4);
      for (int i = 0; i <= D; i++) wr(dat_a, 32'(8'h70 + i));
      rd(sta_a, 32'h0000_0004, 32'h0000_0004);
      rd(ist_a, 32'h0000_0008, 32'h0000_0008);
      wait_got(D + 1);
      idle(40);
      chk(32'(usdp_link_model_i.got.size()), 32'(D + 1));
      chk(32'(usdp_link_model_i.got[0]), 32'h0000_0060);
      for (int i = 0; i < D; i++) begin
         chk(32'(usdp_link_model_i.got[i + 1]), 32'(8'h70 + i));
      end
      conclude();
   end
endmodule

bind uart_shadow_data_port usdp_properties usdp_properties_i (
   .ref_clk(ref_clk), .rstn(rstn), .bus_req(bus_req),
   .rd_data_q(rd_data_q), .sin_rx(sin_rx), .sir_rx(sir_rx),
   .tx_char_q(tx_char_q), .tx_ir_q(tx_ir_q), .tx_take(tx_take),
   .irq_q(irq_q));

`default_nettype wire
